// File: src/ptu_cfg_params.svh
// register map and field layout of the timer channel configuration block
// assumes a 32-bit apb bus, one aligned word per register
`ifndef PTU_CFG_PARAMS_SVH
`define PTU_CFG_PARAMS_SVH

`define PTU_NUM_CH        6
`define PTU_NUM_IOC       8
// channel mode registers at 0x00..0x14
`define PTU_OFS_MODE0     12'h000
// io control registers at 0x20..0x3c
`define PTU_OFS_IOC0      12'h020
// counter run bits, one per channel
`define PTU_OFS_RUN       12'h040
// capture status per channel (a or b capture bit), read only
`define PTU_OFS_STAT      12'h044

`define PTU_MODE_FIXED    8'hc0
`define PTU_MODE_RST      8'hc0
`define PTU_IOC_RST       8'h00
`define PTU_BIT_BUFB      5
`define PTU_BIT_BUFA      4
`define PTU_BIT_MD3       3
`define PTU_MD_LSB        0
`define PTU_MD_MSB        2
`define PTU_FB_MSB        7
`define PTU_FB_LSB        4
`define PTU_FA_MSB        3
`define PTU_FA_LSB        0
// io control register indexes of registers c/d
`define PTU_IOC_CD0       3'h1
`define PTU_IOC_CD3       3'h5

`endif

// File: src/ptu_cfg_pkg.sv
// types of the timer channel configuration block
// assumes ptu_cfg_params.svh gives the numbers
package ptu_cfg_pkg;
	typedef enum logic [7:0] {
		PTU_OP_NORMAL = 8'h01,
		PTU_OP_PWM1   = 8'h02,
		PTU_OP_PWM2   = 8'h04,
		PTU_OP_PHASE1 = 8'h08,
		PTU_OP_PHASE2 = 8'h10,
		PTU_OP_PHASE3 = 8'h20,
		PTU_OP_PHASE4 = 8'h40
	} ptu_op_e;

	typedef enum logic [2:0] {
		PTU_AP_IDLE   = 3'b001,
		PTU_AP_ACCESS = 3'b010,
		PTU_AP_DONE   = 3'b100
	} ptu_apb_e;

	// per-channel configuration handed to the counter core
	typedef struct packed {
		ptu_op_e    op;
		logic       buf_a_en;
		logic       buf_b_en;
		logic       clk_sel_ignore;
		logic [3:0] func_sel_a;
		logic [3:0] func_sel_b;
		logic [3:0] func_sel_c;
		logic [3:0] func_sel_d;
		logic       c_events_en;
		logic       d_events_en;
		logic       init_level_en;
		logic       clear_level_en;
	} ptu_ch_cfg_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ptu_apb_req_s;

	typedef logic [7:0] ptu_byte_t;
endpackage

// File: src/ptu_cfg_regfile.sv
// small register array holding the io control registers
// assumes the main file decodes addresses; read data is registered
`timescale 1ns/1ps
`default_nettype none
`include "ptu_cfg_params.svh"
module ptu_cfg_regfile (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  wr_en,
	input  wire logic [2:0]            wr_idx,
	input  wire ptu_cfg_pkg::ptu_byte_t wr_data,
	input  wire logic [2:0]            rd_idx,
	output ptu_cfg_pkg::ptu_byte_t     rd_data,
	output logic [63:0]                all_q
);
	ptu_cfg_pkg::ptu_byte_t mem_r [`PTU_NUM_IOC];

	genvar gi;
	generate
		for (gi = 0; gi < `PTU_NUM_IOC; gi++) begin : g_ioc
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					mem_r[gi] <= `PTU_IOC_RST;
				else if (wr_en && wr_idx == 3'(gi))
					mem_r[gi] <= wr_data;
			end
			assign all_q[gi*8 +: 8] = mem_r[gi];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_data <= `PTU_IOC_RST;
		else
			rd_data <= mem_r[rd_idx];
	end
endmodule
`default_nettype wire

// File: src/ptu_cfg.sv
// configuration registers of a six-channel pulse timer: mode and io control
// assumes an apb master on pclk; the counter core consumes ch_cfg
//
// Behaviour
// - six 8-bit read/write channel mode registers, one per channel
// - mode bits 7 and 6 read as one, writes ignored
// - buffer-b bit makes d the buffer of b; d makes no events
// - buffer-a bit makes c the buffer of a; c makes no events
// - channels 1,2,4,5 buffer bits read zero, writes ignored
// - low mode bits decode normal, reserved, pwm 1/2, phase 1-4 (phase on ch 1,2,4,5 only)
// - eight 8-bit io control registers: two for ch 0/3, one otherwise
// - initial output level applies only while the run bit is clear
// - pwm mode 2: io setting gives level at counter clear
// - c or d used as buffer ignores its io control setting
// - io bits 7:4 select b function, 3:0 a; reset zero
// - channel 5 ignores its clock selection in phase counting
// - top io field bit set means input capture, edge from low bits
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ptu_cfg_params.svh"
module ptu_cfg (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [3:0]               pstrb,
	output logic                          pready,
	output logic [31:0]                   prdata,
	output logic                          pslverr,
	output ptu_cfg_pkg::ptu_ch_cfg_s [5:0] ch_cfg,
	output logic [5:0]                    counter_run_bit,
	output logic [5:0]                    ch_capture_a,
	output logic [5:0]                    ch_capture_b
);
	// io control index for each channel's a/b register
	localparam logic [2:0] IOC_AB [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};

	ptu_cfg_pkg::ptu_apb_e    ap_r;
	ptu_cfg_pkg::ptu_apb_e    ap_nxt;
	ptu_cfg_pkg::ptu_byte_t   mode_r [6];
	ptu_cfg_pkg::ptu_apb_req_s req;
	logic [5:0]               run_r;
	logic [63:0]              ioc_all;
	ptu_cfg_pkg::ptu_byte_t   ioc_rd;
	logic [31:0]              rdata_nxt;
	logic [31:0]              prdata_r;
	logic                     err_nxt;
	logic                     pslverr_r;
	logic                     acc;
	logic                     wr_acc;
	logic                     sel_mode;
	logic                     sel_ioc;
	logic [2:0]               mode_idx;
	logic [2:0]               ioc_idx;

	function automatic logic has_cd(input int ch);
		return (ch == 0) || (ch == 3);
	endfunction

	function automatic ptu_cfg_pkg::ptu_op_e decode_op(input ptu_cfg_pkg::ptu_byte_t m,
			input logic phase_ok);
		if (m[`PTU_BIT_MD3])
			return ptu_cfg_pkg::PTU_OP_NORMAL;
		case (m[`PTU_MD_MSB:`PTU_MD_LSB])
			3'b010: return ptu_cfg_pkg::PTU_OP_PWM1;
			3'b011: return ptu_cfg_pkg::PTU_OP_PWM2;
			3'b100: return phase_ok ? ptu_cfg_pkg::PTU_OP_PHASE1 : ptu_cfg_pkg::PTU_OP_NORMAL;
			3'b101: return phase_ok ? ptu_cfg_pkg::PTU_OP_PHASE2 : ptu_cfg_pkg::PTU_OP_NORMAL;
			3'b110: return phase_ok ? ptu_cfg_pkg::PTU_OP_PHASE3 : ptu_cfg_pkg::PTU_OP_NORMAL;
			3'b111: return phase_ok ? ptu_cfg_pkg::PTU_OP_PHASE4 : ptu_cfg_pkg::PTU_OP_NORMAL;
			default: return ptu_cfg_pkg::PTU_OP_NORMAL;
		endcase
	endfunction

	function automatic logic is_phase(input ptu_cfg_pkg::ptu_op_e op);
		return op inside {ptu_cfg_pkg::PTU_OP_PHASE1, ptu_cfg_pkg::PTU_OP_PHASE2,
			ptu_cfg_pkg::PTU_OP_PHASE3, ptu_cfg_pkg::PTU_OP_PHASE4};
	endfunction

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// address decode
	always_comb begin
		sel_mode = 1'b0;
		sel_ioc  = 1'b0;
		mode_idx = 3'h0;
		ioc_idx  = 3'h0;
		if (req.paddr[1:0] == 2'b00) begin
			if (req.paddr >= `PTU_OFS_MODE0 && req.paddr < `PTU_OFS_MODE0 + 12'h018) begin
				sel_mode = 1'b1;
				mode_idx = 3'(req.paddr[11:2] - `PTU_OFS_MODE0 / 12'h004);
			end
			if (req.paddr >= `PTU_OFS_IOC0 && req.paddr < `PTU_OFS_IOC0 + 12'h020) begin
				sel_ioc = 1'b1;
				ioc_idx = 3'(req.paddr[11:2] - `PTU_OFS_IOC0 / 12'h004);
			end
		end
	end

	// apb: setup, two wait cycles for the registered read, then ready
	always_comb begin
		case (ap_r)
			ptu_cfg_pkg::PTU_AP_IDLE:
				ap_nxt = (req.psel && req.penable) ? ptu_cfg_pkg::PTU_AP_ACCESS
					: ptu_cfg_pkg::PTU_AP_IDLE;
			ptu_cfg_pkg::PTU_AP_ACCESS:
				ap_nxt = ptu_cfg_pkg::PTU_AP_DONE;
			ptu_cfg_pkg::PTU_AP_DONE:
				ap_nxt = ptu_cfg_pkg::PTU_AP_IDLE;
			default:
				ap_nxt = ptu_cfg_pkg::PTU_AP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ap_r <= ptu_cfg_pkg::PTU_AP_IDLE;
		else
			ap_r <= ap_nxt;
	end

	assign pready  = (ap_r == ptu_cfg_pkg::PTU_AP_DONE);
	assign acc     = req.psel && req.penable && pready;
	assign wr_acc  = acc && req.pwrite && pstrb[0];
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	generate
		for (genvar ch = 0; ch < `PTU_NUM_CH; ch++) begin : g_mode
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mode_r[ch] <= `PTU_MODE_RST;
				end else if (wr_acc && sel_mode && mode_idx == 3'(ch)) begin
					// buffer bits only on c/d channels
					mode_r[ch] <= `PTU_MODE_FIXED
						| {2'b00,
						   has_cd(ch) ? req.pwdata[`PTU_BIT_BUFB] : 1'b0,
						   has_cd(ch) ? req.pwdata[`PTU_BIT_BUFA] : 1'b0,
						   req.pwdata[3:0]};
				end
			end
		end
	endgenerate

	// counter run bits, one per channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_r <= 6'h00;
		else if (wr_acc && req.paddr == `PTU_OFS_RUN)
			run_r <= req.pwdata[5:0];
	end
	assign counter_run_bit = run_r;

	ptu_cfg_regfile u_ioc (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_acc && sel_ioc),
		.wr_idx  (ioc_idx),
		.wr_data (req.pwdata[7:0]),
		.rd_idx  (ioc_idx),
		.rd_data (ioc_rd),
		.all_q   (ioc_all)
	);

	// read mux, captured in the access cycle; io data is registered since setup
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		err_nxt   = 1'b0;
		if (sel_mode && mode_idx < 3'h6)
			rdata_nxt = {24'h00_0000, mode_r[mode_idx]};
		else if (sel_ioc)
			rdata_nxt = {24'h00_0000, ioc_rd};
		else if (req.paddr == `PTU_OFS_RUN)
			rdata_nxt = {26'h000_0000, run_r};
		else if (req.paddr == `PTU_OFS_STAT)
			rdata_nxt = {26'h000_0000, ch_capture_b | ch_capture_a};
		else
			err_nxt = 1'b1;
	end

	// data and error stand only while ready is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (ap_r == ptu_cfg_pkg::PTU_AP_ACCESS) begin
			prdata_r  <= rdata_nxt;
			pslverr_r <= err_nxt;
		end else begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	// per-channel configuration for the counter core
	generate
		for (genvar ch = 0; ch < `PTU_NUM_CH; ch++) begin : g_cfg
			ptu_cfg_pkg::ptu_op_e op;
			logic [7:0] ioab;
			logic [7:0] iocd;
			assign op   = decode_op(mode_r[ch], !has_cd(ch));
			assign ioab = ioc_all[IOC_AB[ch]*8 +: 8];
			// only channels with c and d own a second io register
			if (has_cd(ch)) begin : g_cd
				assign iocd = ioc_all[(IOC_AB[ch]+1)*8 +: 8];
			end else begin : g_no_cd
				assign iocd = 8'h00;
			end
			always_comb begin
				ch_cfg[ch].op         = op;
				ch_cfg[ch].buf_a_en   = mode_r[ch][`PTU_BIT_BUFA];
				ch_cfg[ch].buf_b_en   = mode_r[ch][`PTU_BIT_BUFB];
				ch_cfg[ch].clk_sel_ignore = (ch == 5) && is_phase(op);
				// b in high nibble, a in low
				ch_cfg[ch].func_sel_b = ioab[`PTU_FB_MSB:`PTU_FB_LSB];
				ch_cfg[ch].func_sel_a = ioab[`PTU_FA_MSB:`PTU_FA_LSB];
				ch_cfg[ch].func_sel_c = mode_r[ch][`PTU_BIT_BUFA] ? 4'h0
					: iocd[`PTU_FA_MSB:`PTU_FA_LSB];
				ch_cfg[ch].func_sel_d = mode_r[ch][`PTU_BIT_BUFB] ? 4'h0
					: iocd[`PTU_FB_MSB:`PTU_FB_LSB];
				ch_cfg[ch].c_events_en = has_cd(ch) && !mode_r[ch][`PTU_BIT_BUFA];
				ch_cfg[ch].d_events_en = has_cd(ch) && !mode_r[ch][`PTU_BIT_BUFB];
				ch_cfg[ch].init_level_en = !run_r[ch];
				// level at clear in pwm 2
				ch_cfg[ch].clear_level_en = (op == ptu_cfg_pkg::PTU_OP_PWM2);
			end
			assign ch_capture_a[ch] = ioab[`PTU_FA_MSB];
			assign ch_capture_b[ch] = ioab[`PTU_FB_MSB];
		end
	endgenerate
endmodule
`default_nettype wire

// File: dv/ptu_cfg_monitor.sv
// port checker for the timer channel configuration block
// assumes it is bound onto ptu_cfg
`timescale 1ns/1ps
`default_nettype none
module ptu_cfg_monitor (
	input wire logic                           pclk,
	input wire logic                           presetn,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pready,
	input wire logic                           pslverr,
	input wire ptu_cfg_pkg::ptu_ch_cfg_s [5:0] ch_cfg,
	input wire logic [5:0]                     counter_run_bit,
	input wire logic [5:0]                     ch_capture_a
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_start;
		psel && penable && !$past(penable);
	endsequence
	sequence one_pulse;
		pready ##1 !pready;
	endsequence
	access_len_a: assert property (acc_start |-> ##[1:2] pready)
		else $error("access phase not answered in time");
	ready_pulse_a: assert property (pready |-> one_pulse)
		else $error("ready held longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	no_spare_buf_a: assert property (!(|{ch_cfg[1].buf_a_en, ch_cfg[2].buf_a_en,
		ch_cfg[4].buf_a_en, ch_cfg[5].buf_a_en, ch_cfg[1].buf_b_en, ch_cfg[2].buf_b_en,
		ch_cfg[4].buf_b_en, ch_cfg[5].buf_b_en}))
		else $error("buffer pairing on channel without c/d");
	buf_c_quiet_a: assert property (!(ch_cfg[0].buf_a_en && ch_cfg[0].c_events_en)
		&& !(ch_cfg[3].buf_a_en && ch_cfg[3].c_events_en))
		else $error("buffer c still makes events");
	buf_d_quiet_a: assert property (!(ch_cfg[0].buf_b_en && ch_cfg[0].d_events_en)
		&& !(ch_cfg[3].buf_b_en && ch_cfg[3].d_events_en))
		else $error("buffer d still makes events");
	no_phase_ch03_a: assert property (!(|ch_cfg[0].op[6:3]) && !(|ch_cfg[3].op[6:3]))
		else $error("phase mode on channel 0 or 3");
	clk_ignore_a: assert property (ch_cfg[5].clk_sel_ignore == (|ch_cfg[5].op[6:3]))
		else $error("clock select ignore wrong on channel 5");
	init_level_a: assert property (ch_cfg[0].init_level_en == !counter_run_bit[0])
		else $error("initial level enable not tied to run bit");
	clear_level_a: assert property (ch_cfg[1].clear_level_en ==
		(ch_cfg[1].op == ptu_cfg_pkg::PTU_OP_PWM2)) else $error("clear level wrong");
	capture_sel_a: assert property (ch_capture_a[0] == ch_cfg[0].func_sel_a[3])
		else $error("capture select flag wrong");
endmodule
bind ptu_cfg ptu_cfg_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .ch_cfg(ch_cfg),
	.counter_run_bit(counter_run_bit), .ch_capture_a(ch_capture_a));
`default_nettype wire

// File: dv/timer_channel_mode_io_config_tb_top.sv
// self-checking bench of the timer channel configuration block
// assumes ptu_cfg with its checker bound; apb master in this module
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_io_config_tb_top;
	logic                           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]                    paddr = '0;
	logic [31:0]                    pwdata = '0, rd, prdata;
	logic [3:0]                     pstrb = '0;
	logic                           pready, pslverr, er;
	ptu_cfg_pkg::ptu_ch_cfg_s [5:0] ch_cfg;
	logic [5:0]                     run, cap_a, cap_b;
	logic [15:0]                    lf = 16'h8f8b;
	logic [7:0]                     m [6];
	logic [7:0]                     io [8];
	int                             ab [6] = '{0, 2, 3, 4, 6, 7};
	int                             errors = 0, check_count = 0;
	always #12.5 pclk = ~pclk;
	ptu_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .ch_cfg(ch_cfg), .counter_run_bit(run),
		.ch_capture_a(cap_a), .ch_capture_b(cap_b));
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// expected one-hot operating mode
	function automatic logic [7:0] op_of(input int c, input logic [3:0] md);
		if (md[3] || md[2:0] == 3'h1 || (md[2] && (c == 0 || c == 3)))
			return ptu_cfg_pkg::PTU_OP_NORMAL;
		if (md[2])
			return ptu_cfg_pkg::PTU_OP_PHASE1 << md[1:0];
		return md[1] ? (md[0] ? ptu_cfg_pkg::PTU_OP_PWM2 : ptu_cfg_pkg::PTU_OP_PWM1)
			: ptu_cfg_pkg::PTU_OP_NORMAL;
	endfunction
	function automatic logic [7:0] mode_rb(input int c, input logic [7:0] d);
		return {2'b11, (c == 0 || c == 3) ? d[5:4] : 2'b00, d[3:0]};
	endfunction
	// c/d function fields, zero while the register buffers
	function automatic logic [7:0] cd_of(input logic [7:0] md, input logic [7:0] v);
		return {md[5] ? 4'h0 : v[7:4], md[4] ? 4'h0 : v[3:0]};
	endfunction
	// c/d event enables, only on channels that own c and d
	function automatic logic [1:0] ev_of(input int c, input logic [7:0] md);
		return (c == 0 || c == 3) ? ~md[5:4] : 2'b00;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		if (n >= 16)
			errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic stop_test();
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		int c;
		logic [7:0] d;
		logic [7:0] o;
		logic [31:0] st;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (c = 0; c < 6; c++) begin
			apb(0, 12'(4 * c), 0, 4'h0);
			chk("mode reset", 32'h0000_00c0, rd);
			chk("io reset", 0, {ch_cfg[c].func_sel_a, ch_cfg[c].func_sel_b});
			m[c] = 8'hc0;
		end
		// every mode write below happens with all run bits clear
		for (int k = 0; k < 16; k++) begin
			apb(1, 12'h004, 32'(k), 4'h1);
			apb(0, 12'h004, 0, 4'h0);
			chk("mode rb", 32'(mode_rb(1, 8'(k))), rd);
			chk("op", 32'(op_of(1, k[3:0])), 32'(ch_cfg[1].op));
			m[1] = mode_rb(1, 8'(k));
		end
		repeat (40) begin
			c = int'(lf[2:0]) % 6;
			d = lf[15:8] & ((c == 0 || c == 3) ? 8'hf3 : 8'hf7);
			lf = nx(lf);
			apb(1, 12'(4 * c), {24'h0, d}, 4'h1);
			apb(0, 12'(4 * c), 0, 4'h0);
			m[c] = mode_rb(c, d);
			o = op_of(c, d[3:0]);
			chk("mode rb", 32'(m[c]), rd);
			chk("op", 32'(o), 32'(ch_cfg[c].op));
			chk("buf", 32'(m[c][5:4]), {ch_cfg[c].buf_b_en, ch_cfg[c].buf_a_en});
			chk("clr", 32'(o == ptu_cfg_pkg::PTU_OP_PWM2), ch_cfg[c].clear_level_en);
			chk("clk ign", 32'(c == 5 && o[6:3] != 4'h0), ch_cfg[c].clk_sel_ignore);
		end
		apb(1, 12'h008, 32'h0000_0003, 4'he);
		apb(0, 12'h008, 0, 4'h0);
		chk("strobe off", 32'(m[2]), rd);
		for (int k = 0; k < 8; k++) begin
			io[k] = lf[7:0];
			lf = nx(lf);
			apb(0, 12'h020 + 12'(4 * k), 0, 4'h0);
			chk("io reset", 0, rd);
			apb(1, 12'h020 + 12'(4 * k), {24'h0, io[k]}, 4'h1);
			apb(0, 12'h020 + 12'(4 * k), 0, 4'h0);
			chk("io rb", 32'(io[k]), rd);
		end
		st = 0;
		for (c = 0; c < 6; c++) begin
			d = io[ab[c]];
			chk("fsel", 32'(d), {ch_cfg[c].func_sel_b, ch_cfg[c].func_sel_a});
			chk("cap", {d[7], d[3]}, {cap_b[c], cap_a[c]});
			chk("ev", 32'(ev_of(c, m[c])),
				{ch_cfg[c].d_events_en, ch_cfg[c].c_events_en});
			st[c] = d[7] | d[3];
		end
		// buffer pairing corners on the channels with c and d
		for (c = 0; c < 6; c += 3) begin
			for (int b = 0; b < 4; b++) begin
				d = 8'(b << 4);
				apb(1, 12'(4 * c), {24'h0, d}, 4'h1);
				m[c] = mode_rb(c, d);
				chk("cd", 32'(cd_of(m[c], io[ab[c] + 1])),
					{ch_cfg[c].func_sel_d, ch_cfg[c].func_sel_c});
				chk("cd ev", 32'(ev_of(c, m[c])),
					{ch_cfg[c].d_events_en, ch_cfg[c].c_events_en});
			end
		end
		apb(0, 12'h044, 0, 4'h0);
		chk("status", st, rd);
		chk("status err", 0, er);
		apb(1, 12'h040, 32'h0000_003f, 4'h1);
		apb(0, 12'h040, 0, 4'h0);
		chk("run", 32'h0000_003f, rd);
		chk("run pins", 32'h0000_003f, run);
		chk("init lvl", 0, ch_cfg[2].init_level_en);
		apb(1, 12'h040, 0, 4'h1);
		chk("init lvl", 1, ch_cfg[2].init_level_en);
		apb(0, 12'h100, 0, 4'h0);
		chk("slverr", 1, er);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
